// File: verilog/dei_regs.svh
// Offsets, field positions, reset values and widths of the error
// interrupt block. Definitions only; included by the package and modules.
`ifndef DEI_REGS_SVH
`define DEI_REGS_SVH

`define DEI_ADDR_W 8
`define DEI_DATA_W 8

`define DEI_OUT_CTRL_ADDR 8'hE0
`define DEI_SRC_MASK_ADDR 8'hE1
`define DEI_SRC_STAT_ADDR 8'hE5

`define DEI_IRQ_EN_BIT 0
`define DEI_SYNC_BIT 7
`define DEI_CHECKSUM_BIT 6
`define DEI_UNCORR_BIT 5
`define DEI_CORR_BIT 4
`define DEI_PROTO_BIT 3
`define DEI_LEADER_BIT 2
`define DEI_UNLOCK_BIT 0

`define DEI_OUT_CTRL_RST 8'h00
`define DEI_SRC_MASK_RST 8'h00
`define DEI_SRC_STAT_RST 8'h01

`define DEI_OUT_CTRL_VALID 8'h01
`define DEI_SRC_VALID 8'hFD

`define DEI_PROTO_SRC_N 6
`define DEI_SYNC_STAGES 2

`endif

// File: verilog/dei_pkg.sv
// Types of the error interrupt block.
// Assumes dei_regs.svh is on the include path.
`include "dei_regs.svh"

package dei_pkg;

	typedef logic [`DEI_DATA_W-1:0] dei_byte_t;

	typedef struct packed {
		dei_byte_t flags;
	} dei_flag_state_t;

	typedef struct packed {
		logic irq_en;
		dei_byte_t mask;
		logic [`DEI_SYNC_STAGES-1:0] lock_sync;
		logic lock_prev;
		dei_byte_t rdata;
	} dei_top_state_t;

endpackage

// File: verilog/dei_flag_if.sv
// Set, clear and state lines between the register logic and the flag bank.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`include "dei_regs.svh"

interface dei_flag_if;
	logic [`DEI_DATA_W-1:0] set;
	logic [`DEI_DATA_W-1:0] clr;
	logic [`DEI_DATA_W-1:0] flags;

	modport bank (input set, input clr, output flags);
	modport ctrl (output set, output clr, input flags);
endinterface

// File: verilog/dei_flag_bank.sv
// Sticky status flags with write-one-to-clear.
// Assumes set and clr are synchronous to clk_sys_i.
`timescale 1ns/1ps
`include "dei_regs.svh"

module dei_flag_bank
(
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	dei_flag_if.bank fl
);

	dei_pkg::dei_flag_state_t st_reg;
	dei_pkg::dei_flag_state_t st_next;

	always_comb
	begin
		st_next = st_reg;
		// Set wins over a clear in the same cycle; reserved bits stay zero
		st_next.flags = ((st_reg.flags & ~fl.clr) | fl.set)
			& `DEI_SRC_VALID;
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			st_reg <= '{flags: `DEI_SRC_STAT_RST};
		else
			st_reg <= st_next;
	end

	assign fl.flags = st_reg.flags;

	property p_hold_without_clear;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		1'b1 |=> (($past(fl.flags) & ~$past(fl.clr)) & ~fl.flags) == 8'h00;
	endproperty
	a_hold_without_clear: assert property (p_hold_without_clear)
		else $error("flag dropped without a clearing write");

	property p_clear_takes;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(fl.clr & ~fl.set) != 8'h00 |=>
			(fl.flags & $past(fl.clr) & ~$past(fl.set)) == 8'h00;
	endproperty
	a_clear_takes: assert property (p_clear_takes)
		else $error("flag not cleared by write of one");

	property p_set_beats_clear;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(fl.set & fl.clr) != 8'h00 |=>
			(fl.flags & $past(fl.set) & $past(fl.clr))
			== ($past(fl.set) & $past(fl.clr));
	endproperty
	a_set_beats_clear: assert property (p_set_beats_clear)
		else $error("event lost against a simultaneous clear");

	c_set_and_clear: cover property (@(posedge clk_sys_i)
		disable iff (!arst_n_i) (fl.set & fl.clr) != 8'h00);

endmodule

// File: verilog/dei_irq_top.sv
// Error status, source mask and interrupt pin control of the DSI bridge.
// Assumes event inputs are one-cycle pulses on clk_sys_i; pll_lock_i is
// asynchronous. The pin wire is resolved outside from irq_o and irq_oe_o.
//
// Operation
// - Pin stays undriven while global enable is 0, its reset value.
// - Enable at 1: pin driven high when any unmasked status flag is set.
// - Mask bits 7..2 and 0 gate their flags; all reset to 0.
// - Unexpected sync packet event sets status bit 7.
// - Payload CRC mismatch event sets status bit 6.
// - Uncorrectable header ECC error sets status bit 5.
// - Corrected header ECC error sets status bit 4.
// - Low-level protocol error sets status bit 3.
// - Bit 3 also catches SoT/EoT, escape, LP sync, false control, merge.
// - Leader sequence bit error sets status bit 2.
// - Lock-to-unlock transition sets bit 0; bit 0 resets to 1.
// - Flags stay set until a one is written; zero leaves them.
// - Writing one clears any flag, the unlock flag included, except one whose event fires in that cycle.
`timescale 1ns/1ps
`include "dei_regs.svh"

module dei_irq_top
(
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic [`DEI_ADDR_W-1:0] csr_addr_i,
	input wire logic csr_wr_i,
	input wire logic csr_rd_i,
	input wire logic [`DEI_DATA_W-1:0] csr_wdata_i,
	output logic [`DEI_DATA_W-1:0] csr_rdata_o,
	input wire logic sync_fault_evt_i,
	input wire logic payload_checksum_fault_evt_i,
	input wire logic uncorrectable_header_fault_evt_i,
	input wire logic corrected_header_fault_evt_i,
	input wire logic [`DEI_PROTO_SRC_N-1:0] protocol_fault_evt_i,
	input wire logic leader_bit_fault_evt_i,
	input wire logic pll_lock_i,
	output logic irq_o,
	output logic irq_oe_o
);

	dei_pkg::dei_top_state_t st_reg;
	dei_pkg::dei_top_state_t st_next;
	dei_flag_if fl ();
	logic lock_fall;
	logic active;

	function automatic logic hit(input logic [`DEI_ADDR_W-1:0] a,
		input logic [`DEI_ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	dei_flag_bank u_flags
	(
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.fl(fl.bank)
	);

	// Lock is read only after the second synchroniser stage
	assign lock_fall = st_reg.lock_prev & ~st_reg.lock_sync[1];

	always_comb
	begin
		fl.set = 8'h00;
		fl.set[`DEI_SYNC_BIT] = sync_fault_evt_i;
		fl.set[`DEI_CHECKSUM_BIT] = payload_checksum_fault_evt_i;
		fl.set[`DEI_UNCORR_BIT] = uncorrectable_header_fault_evt_i;
		fl.set[`DEI_CORR_BIT] = corrected_header_fault_evt_i;
		fl.set[`DEI_PROTO_BIT] = |protocol_fault_evt_i;
		fl.set[`DEI_LEADER_BIT] = leader_bit_fault_evt_i;
		fl.set[`DEI_UNLOCK_BIT] = lock_fall;
	end

	// Only ones written to implemented bits clear
	assign fl.clr = (csr_wr_i && hit(csr_addr_i, `DEI_SRC_STAT_ADDR))
		? (csr_wdata_i & `DEI_SRC_VALID) : 8'h00;

	always_comb
	begin
		st_next = st_reg;
		st_next.lock_sync = {st_reg.lock_sync[0], pll_lock_i};
		st_next.lock_prev = st_reg.lock_sync[1];
		if (csr_wr_i && hit(csr_addr_i, `DEI_OUT_CTRL_ADDR))
			st_next.irq_en = csr_wdata_i[`DEI_IRQ_EN_BIT];
		if (csr_wr_i && hit(csr_addr_i, `DEI_SRC_MASK_ADDR))
			st_next.mask = csr_wdata_i & `DEI_SRC_VALID;
		if (csr_rd_i)
		begin
			if (hit(csr_addr_i, `DEI_OUT_CTRL_ADDR))
				st_next.rdata = {7'h00, st_reg.irq_en};
			else if (hit(csr_addr_i, `DEI_SRC_MASK_ADDR))
				st_next.rdata = st_reg.mask;
			else if (hit(csr_addr_i, `DEI_SRC_STAT_ADDR))
				st_next.rdata = fl.flags;
			else
				st_next.rdata = 8'h00;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			st_reg <= '{irq_en: 1'b0, mask: `DEI_SRC_MASK_RST,
				lock_sync: 2'h0, lock_prev: 1'b0,
				rdata: 8'h00};
		else
			st_reg <= st_next;
	end

	assign active = |(fl.flags & st_reg.mask);
	// Pin is only ever driven high; otherwise it floats
	assign irq_oe_o = st_reg.irq_en & active;
	assign irq_o = irq_oe_o;
	assign csr_rdata_o = st_reg.rdata;

	property p_float_when_off;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		!st_reg.irq_en |-> !irq_oe_o;
	endproperty
	a_float_when_off: assert property (p_float_when_off)
		else $error("interrupt pin driven while disabled");

	property p_drive_on_flag;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(st_reg.irq_en && (fl.flags & st_reg.mask) != 8'h00)
			|-> (irq_oe_o && irq_o);
	endproperty
	a_drive_on_flag: assert property (p_drive_on_flag)
		else $error("interrupt pin not driven high");

	property p_mask_gates;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(fl.flags & st_reg.mask) == 8'h00 |-> !irq_oe_o;
	endproperty
	a_mask_gates: assert property (p_mask_gates)
		else $error("masked flag reached the pin");

	property p_sync_sets;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		sync_fault_evt_i |=> fl.flags[`DEI_SYNC_BIT];
	endproperty
	a_sync_sets: assert property (p_sync_sets)
		else $error("sync fault flag not set");

	property p_checksum_sets;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		payload_checksum_fault_evt_i |=> fl.flags[`DEI_CHECKSUM_BIT];
	endproperty
	a_checksum_sets: assert property (p_checksum_sets)
		else $error("payload checksum flag not set");

	property p_uncorr_sets;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		uncorrectable_header_fault_evt_i |=> fl.flags[`DEI_UNCORR_BIT];
	endproperty
	a_uncorr_sets: assert property (p_uncorr_sets)
		else $error("uncorrectable header flag not set");

	property p_corr_sets;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		corrected_header_fault_evt_i |=> fl.flags[`DEI_CORR_BIT];
	endproperty
	a_corr_sets: assert property (p_corr_sets)
		else $error("corrected header flag not set");

	property p_proto_sets;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(protocol_fault_evt_i != 6'h00) |=> fl.flags[`DEI_PROTO_BIT];
	endproperty
	a_proto_sets: assert property (p_proto_sets)
		else $error("protocol fault flag not set");

	property p_leader_sets;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		leader_bit_fault_evt_i |=> fl.flags[`DEI_LEADER_BIT];
	endproperty
	a_leader_sets: assert property (p_leader_sets)
		else $error("leader bit flag not set");

	property p_unlock_sets;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		$fell(st_reg.lock_sync[1]) |=> fl.flags[`DEI_UNLOCK_BIT];
	endproperty
	a_unlock_sets: assert property (p_unlock_sets)
		else $error("unlock flag not set on lock loss");

	property p_reserved_zero;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(csr_rd_i && hit(csr_addr_i, `DEI_OUT_CTRL_ADDR)) |=>
			csr_rdata_o[7:1] == 7'h00 ##0 (fl.flags[1] == 1'b0)
			##0 (st_reg.mask[1] == 1'b0);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved bit reads as one");

	property p_enable_lands;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(csr_wr_i && hit(csr_addr_i, `DEI_OUT_CTRL_ADDR)) |=>
			{7'h00, st_reg.irq_en}
			== ($past(csr_wdata_i) & `DEI_OUT_CTRL_VALID);
	endproperty
	a_enable_lands: assert property (p_enable_lands)
		else $error("global enable write did not land");

	property p_mask_lands;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(csr_wr_i && hit(csr_addr_i, `DEI_SRC_MASK_ADDR)) |=>
			st_reg.mask == ($past(csr_wdata_i) & `DEI_SRC_VALID);
	endproperty
	a_mask_lands: assert property (p_mask_lands)
		else $error("mask write did not land");

	// Unlock flag may only come up through a seen lock loss
	property p_unlock_needs_fall;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		$rose(fl.flags[`DEI_UNLOCK_BIT]) |-> $past(lock_fall);
	endproperty
	a_unlock_needs_fall: assert property (p_unlock_needs_fall)
		else $error("unlock flag set without lock loss");

	c_irq_driven: cover property (@(posedge clk_sys_i)
		disable iff (!arst_n_i) $rose(irq_oe_o));
	c_irq_cleared: cover property (@(posedge clk_sys_i)
		disable iff (!arst_n_i) irq_oe_o ##1 !irq_oe_o);
	c_lock_lost: cover property (@(posedge clk_sys_i)
		disable iff (!arst_n_i) lock_fall);

endmodule

// File: dv/dsi_error_irq_aggregator_test.sv
// Self-checking bench for the error interrupt block: register access,
// event flags, masking, pin enable and lock loss detection.
// Assumes dei_regs.svh is on the include path; assertions sit in the design.
`timescale 1ns/1ps
`include "dei_regs.svh"

module dsi_error_irq_aggregator_test;
	logic clk_sys_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [`DEI_ADDR_W-1:0] addr = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [`DEI_DATA_W-1:0] wdata = 8'h00;
	logic [`DEI_DATA_W-1:0] rdata;
	logic [10:0] ev = 11'h000;
	logic pll_lock = 1'b1;
	logic irq;
	logic irq_oe;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;

	always #20 clk_sys_i = ~clk_sys_i;

	dei_irq_top DUT
	(
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.csr_addr_i(addr),
		.csr_wr_i(wr),
		.csr_rd_i(rd),
		.csr_wdata_i(wdata),
		.csr_rdata_o(rdata),
		.sync_fault_evt_i(ev[10]),
		.payload_checksum_fault_evt_i(ev[9]),
		.uncorrectable_header_fault_evt_i(ev[8]),
		.corrected_header_fault_evt_i(ev[7]),
		.protocol_fault_evt_i(ev[6:1]),
		.leader_bit_fault_evt_i(ev[0]),
		.pll_lock_i(pll_lock),
		.irq_o(irq),
		.irq_oe_o(irq_oe)
	);

	task automatic print_verdict();
		if (n_fail == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e)
		begin
			$display("MISMATCH %0t read %h expected %h", $time, g, e);
			n_fail++;
		end
	endtask

	task automatic chk_irq(input logic e);
		#1;
		total_checks++;
		if (irq_oe !== e || irq !== e)
		begin
			$display("MISMATCH %0t pin %b/%b expected %b", $time, irq_oe,
				irq, e);
			n_fail++;
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys_i);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_i);
		rd <= 1'b0;
		#1;
		chk8(rdata, e);
	endtask

	task automatic pulse(input int i);
		@(posedge clk_sys_i);
		ev <= 11'h001 << i;
		@(posedge clk_sys_i);
		ev <= 11'h000;
	endtask

	// Index 0 leader, 1..6 protocol sources, 7..10 header/checksum/sync
	function automatic int flag_pos(input int i);
		if (i == 0)
			return 2;
		if (i < 7)
			return 3;
		return i - 3;
	endfunction

	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_fail++;
			print_verdict();
		end
	end

	initial
	begin
		logic [7:0] b;
		repeat (12) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		rd_chk(`DEI_OUT_CTRL_ADDR, 8'h00);
		chk_irq(1'b0);
		rd_chk(`DEI_SRC_MASK_ADDR, 8'h00);
		rd_chk(`DEI_SRC_STAT_ADDR, 8'h01);
		rd_chk(8'h42, 8'h00);
		wr_reg(`DEI_OUT_CTRL_ADDR, 8'hFF);
		rd_chk(`DEI_OUT_CTRL_ADDR, 8'h01);
		chk_irq(1'b0);
		wr_reg(`DEI_SRC_MASK_ADDR, 8'hFF);
		rd_chk(`DEI_SRC_MASK_ADDR, 8'hFD);
		chk_irq(1'b1);
		wr_reg(`DEI_SRC_STAT_ADDR, 8'h00);
		rd_chk(`DEI_SRC_STAT_ADDR, 8'h01);
		wr_reg(`DEI_SRC_STAT_ADDR, 8'hFF);
		rd_chk(`DEI_SRC_STAT_ADDR, 8'h00);
		chk_irq(1'b0);
		for (int i = 0; i < 11; i++)
		begin
			b = 8'h01 << flag_pos(i);
			pulse(i);
			rd_chk(`DEI_SRC_STAT_ADDR, b);
			chk_irq(1'b1);
			wr_reg(`DEI_SRC_MASK_ADDR, 8'hFD & ~b);
			chk_irq(1'b0);
			wr_reg(`DEI_SRC_MASK_ADDR, 8'hFD);
			wr_reg(`DEI_OUT_CTRL_ADDR, 8'h00);
			chk_irq(1'b0);
			wr_reg(`DEI_OUT_CTRL_ADDR, 8'h01);
			wr_reg(`DEI_SRC_STAT_ADDR, ~b);
			rd_chk(`DEI_SRC_STAT_ADDR, b);
			wr_reg(`DEI_SRC_STAT_ADDR, b);
			rd_chk(`DEI_SRC_STAT_ADDR, 8'h00);
			chk_irq(1'b0);
		end
		// Clearing write and new event land on the same edge
		@(posedge clk_sys_i);
		addr <= `DEI_SRC_STAT_ADDR;
		wdata <= 8'h80;
		wr <= 1'b1;
		ev[10] <= 1'b1;
		@(posedge clk_sys_i);
		wr <= 1'b0;
		ev <= 11'h000;
		rd_chk(`DEI_SRC_STAT_ADDR, 8'h80);
		wr_reg(`DEI_SRC_STAT_ADDR, 8'hFF);
		@(posedge clk_sys_i);
		pll_lock <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		rd_chk(`DEI_SRC_STAT_ADDR, 8'h01);
		chk_irq(1'b1);
		@(posedge clk_sys_i);
		pll_lock <= 1'b1;
		wr_reg(`DEI_SRC_STAT_ADDR, 8'h01);
		repeat (6) @(posedge clk_sys_i);
		rd_chk(`DEI_SRC_STAT_ADDR, 8'h00);
		chk_irq(1'b0);
		// Reset in mid-run with the pin driven must restore all registers
		pulse(10);
		chk_irq(1'b1);
		@(posedge clk_sys_i);
		arst_n_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		chk_irq(1'b0);
		wr_reg(8'hE4, 8'hFF);
		rd_chk(`DEI_OUT_CTRL_ADDR, 8'h00);
		rd_chk(`DEI_SRC_MASK_ADDR, 8'h00);
		rd_chk(`DEI_SRC_STAT_ADDR, 8'h01);
		print_verdict();
	end
endmodule
